// ===== src/tpcr_test_page_regs.sv
// Test-page control registers: page override, secure clock, probes, pins, PRBS.
// Assumes the host interface logic delivers address and strobes on CLK.
`include "tpcr_params.svh"
module tpcr_test_page_regs
  import tpcr_pkg::*;
(
  input  wire logic          CLK,
  input  wire logic          SYS_RST,
  input  wire tpcr_host_if_t HOST_IF,
  input  wire tpcr_req_t     HOST_REQ,
  input  wire logic [5:0]    ADDR_LATCH,
  input  wire logic [3:0]    ADDR_LOW,
  input  wire logic [255:0]  TEST_BUS_ALL,
  input  wire logic          OSC_CLK_IN,
  input  wire logic          UART_CLK_IN,
  input  wire logic          RF_CLK_IN,
  input  wire logic [6:0]    PORT_PIN_VALUES,
  input  wire logic          PORT_GPIO_ENABLE,
  input  wire logic          TX_CMD,
  input  wire logic          TX_BIT_ADV,
  output logic      [5:0]    EFF_ADDR,
  output logic      [7:0]    RD_DATA,
  output logic               RD_HIT,
  output logic               SIGNAL_OUTPUT_PIN,
  output logic      [6:0]    PROBE_PORT,
  output tpcr_port_t         D_PORT,
  output logic               SECURE_CLK_OUT,
  output logic               UART_AUX_LINE_A_EN,
  output logic               UART_AUX_LINE_B_EN,
  output logic               PRBS_BIT,
  output logic               PRBS_RUN
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  logic [7:0] page_r;
  logic [7:0] sel_one_r;
  logic [7:0] sel_two_r;
  logic [7:0] pin_en_r;
  logic [5:0] addr_nxt;
  logic [7:0] rd_nxt;
  logic       hit_nxt;
  logic [2:0] clk_sync;
  logic       sec_clk_nxt;
  logic [7:0] group_bus;
  logic [6:0] probe_nxt;
  logic [6:0] pin_mask;
  tpcr_port_t port_nxt;

  logic       page_override_enable;
  logic [1:0] page_number;
  logic [1:0] secure_clock_source;
  logic       secure_clock_to_pin_one;
  logic [2:0] probe_bit_choice;
  logic       probe_port_reorder;
  logic       prbs9_enable;
  logic       prbs15_enable;
  logic [4:0] probe_group_choice;
  logic       uart_aux_lines_enable;
  logic [6:0] port_driver_enables;
  logic       serial_host;

  assign page_override_enable    = page_r[`TPCR_POS_PAGE_OVR];
  assign page_number             = page_r[`TPCR_POS_PAGE_NUM +: 2];
  assign secure_clock_source     = sel_one_r[`TPCR_POS_CLK_SRC +: 2];
  assign secure_clock_to_pin_one = sel_one_r[`TPCR_POS_CLK_D1];
  assign probe_bit_choice        = sel_one_r[`TPCR_POS_PROBE_BIT +: 3];
  assign probe_port_reorder      = sel_two_r[`TPCR_POS_REORDER];
  assign prbs9_enable            = sel_two_r[`TPCR_POS_PRBS9];
  assign prbs15_enable           = sel_two_r[`TPCR_POS_PRBS15];
  assign probe_group_choice      = sel_two_r[`TPCR_POS_GROUP +: 5];
  assign uart_aux_lines_enable   = pin_en_r[`TPCR_POS_AUX_EN];
  assign port_driver_enables     = pin_en_r[`TPCR_POS_DRV_EN +: 7];
  assign serial_host             = (HOST_IF != TPCR_IF_PARALLEL);

  // ***************************************************************
  // register address formation
  // ***************************************************************
  always_comb begin
    if (page_override_enable) begin
      addr_nxt = {page_number, ADDR_LOW};
    end else begin
      addr_nxt = ADDR_LATCH;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      EFF_ADDR <= 6'h00;
    end else begin
      EFF_ADDR <= addr_nxt;
    end
  end

  // ***************************************************************
  // register writes; reserved bits masked off
  // ***************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      page_r <= `TPCR_RST_PAGE;
    end else if (HOST_REQ.wr && (addr_nxt == `TPCR_OFS_PAGE)) begin
      page_r <= HOST_REQ.wdata & `TPCR_WMASK_PAGE;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sel_one_r <= `TPCR_RST_SEL_ONE;
    end else if (HOST_REQ.wr && (addr_nxt == `TPCR_OFS_SEL_ONE)) begin
      sel_one_r <= HOST_REQ.wdata & `TPCR_WMASK_SEL_ONE;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sel_two_r <= `TPCR_RST_SEL_TWO;
    end else if (HOST_REQ.wr && (addr_nxt == `TPCR_OFS_SEL_TWO)) begin
      sel_two_r <= HOST_REQ.wdata & `TPCR_WMASK_SEL_TWO;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pin_en_r <= `TPCR_RST_PIN_EN;
    end else if (HOST_REQ.wr && (addr_nxt == `TPCR_OFS_PIN_EN)) begin
      pin_en_r <= HOST_REQ.wdata & `TPCR_WMASK_PIN_EN;
    end
  end

  // ***************************************************************
  // register reads
  // ***************************************************************
  always_comb begin
    rd_nxt  = 8'h00;
    hit_nxt = 1'b1;
    unique case (addr_nxt)
      `TPCR_OFS_PAGE:    rd_nxt = page_r;
      `TPCR_OFS_SEL_ONE: rd_nxt = sel_one_r;
      `TPCR_OFS_SEL_TWO: rd_nxt = sel_two_r;
      `TPCR_OFS_PIN_EN:  rd_nxt = pin_en_r;
      default:           hit_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RD_DATA <= 8'h00;
      RD_HIT  <= 1'b0;
    end else if (HOST_REQ.rd) begin
      RD_DATA <= rd_nxt;
      RD_HIT  <= hit_nxt;
    end
  end

  // ***************************************************************
  // secure-module clock selection
  // ***************************************************************
  tpcr_sync3 #(
    .W (3)
  ) u_clk_sync (
    .clk (CLK),
    .rst (SYS_RST),
    .d   ({RF_CLK_IN, UART_CLK_IN, OSC_CLK_IN}),
    .q   (clk_sync)
  );

  always_comb begin
    unique case (secure_clock_source)
      2'h0: sec_clk_nxt = 1'b0;
      2'h1: sec_clk_nxt = clk_sync[0];
      2'h2: sec_clk_nxt = clk_sync[1];
      2'h3: sec_clk_nxt = clk_sync[2];
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SECURE_CLK_OUT <= 1'b0;
    end else begin
      SECURE_CLK_OUT <= sec_clk_nxt;
    end
  end

  // ***************************************************************
  // test bus probes
  // ***************************************************************
  assign group_bus = TEST_BUS_ALL[{probe_group_choice, 3'h0} +: 8];

  always_comb begin
    if (probe_port_reorder) begin
      probe_nxt[4] = group_bus[6];
      probe_nxt[3] = group_bus[5];
      probe_nxt[2] = group_bus[4];
      probe_nxt[6] = group_bus[3];
      probe_nxt[5] = group_bus[2];
      probe_nxt[0] = group_bus[1];
      probe_nxt[1] = group_bus[0];
    end else begin
      probe_nxt = group_bus[6:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SIGNAL_OUTPUT_PIN <= 1'b0;
      PROBE_PORT        <= 7'h00;
    end else begin
      SIGNAL_OUTPUT_PIN <= group_bus[probe_bit_choice];
      PROBE_PORT        <= probe_nxt;
    end
  end

  // ***************************************************************
  // parallel pin drivers and UART aux lines
  // ***************************************************************
  always_comb begin
    unique case (HOST_IF)
      TPCR_IF_PARALLEL: pin_mask = 7'h00;
      TPCR_IF_SPI:      pin_mask = `TPCR_SERIAL_PIN_MASK;
      TPCR_IF_UART:     pin_mask = uart_aux_lines_enable ? `TPCR_SERIAL_PIN_MASK : `TPCR_ALL_PIN_MASK;
      TPCR_IF_I2C:      pin_mask = `TPCR_ALL_PIN_MASK;
    endcase
  end

  always_comb begin
    port_nxt.dout = PORT_PIN_VALUES;
    port_nxt.oe   = port_driver_enables & pin_mask & {7{PORT_GPIO_ENABLE}};
    if (secure_clock_to_pin_one && serial_host) begin
      port_nxt.oe[1]   = 1'b1;
      port_nxt.dout[1] = sec_clk_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      D_PORT <= '0;
    end else begin
      D_PORT <= port_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      UART_AUX_LINE_A_EN <= 1'b1;
      UART_AUX_LINE_B_EN <= 1'b1;
    end else begin
      UART_AUX_LINE_A_EN <= uart_aux_lines_enable;
      UART_AUX_LINE_B_EN <= uart_aux_lines_enable;
    end
  end

  // ***************************************************************
  // PRBS generator; host sets up transmit registers first
  // ***************************************************************
  tpcr_prbs_gen u_prbs (
    .clk     (CLK),
    .rst     (SYS_RST),
    .en9     (prbs9_enable),
    .en15    (prbs15_enable),
    .start   (TX_CMD),
    .adv     (TX_BIT_ADV),
    .bit_out (PRBS_BIT),
    .run     (PRBS_RUN)
  );

  // ***************************************************************
  // checks
  // ***************************************************************
  sequence s_armed_no_cmd;
    !TX_CMD ##1 ((prbs9_enable || prbs15_enable) && !PRBS_RUN && !TX_CMD);
  endsequence

  sequence s_stays_idle;
    !PRBS_RUN [*2];
  endsequence

  chk_page_high_bits: assert property (@(posedge CLK) disable iff (SYS_RST)
    page_override_enable |=> EFF_ADDR == {$past(page_number), $past(ADDR_LOW)})
    else $error("override address not formed from page bits");

  chk_latch_address: assert property (@(posedge CLK) disable iff (SYS_RST)
    !page_override_enable |=> EFF_ADDR == $past(ADDR_LATCH))
    else $error("address not taken from latch");

  chk_page_ignored: assert property (@(posedge CLK) disable iff (SYS_RST)
    !page_override_enable && (page_number != ADDR_LATCH[5:4]) |=>
      EFF_ADDR[5:4] != $past(page_number))
    else $error("page number used without override");

  chk_clock_off: assert property (@(posedge CLK) disable iff (SYS_RST)
    (secure_clock_source == 2'h0) |=> !SECURE_CLK_OUT)
    else $error("secure clock not off");

  chk_clock_source: assert property (@(posedge CLK) disable iff (SYS_RST)
    (secure_clock_source == 2'h3) |=> SECURE_CLK_OUT == $past(clk_sync[2]))
    else $error("secure clock not from rf source");

  chk_clock_on_d1: assert property (@(posedge CLK) disable iff (SYS_RST)
    secure_clock_to_pin_one && serial_host |=> D_PORT.oe[1] && (D_PORT.dout[1] == SECURE_CLK_OUT))
    else $error("secure clock not on D1");

  chk_probe_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> SIGNAL_OUTPUT_PIN == $past(TEST_BUS_ALL[{probe_group_choice, probe_bit_choice}]))
    else $error("wrong probe bit on signal pin");

  chk_probe_order: assert property (@(posedge CLK) disable iff (SYS_RST)
    probe_port_reorder |=> (PROBE_PORT[4] == $past(group_bus[6])) && (PROBE_PORT[1] == $past(group_bus[0]))
      && (PROBE_PORT[6] == $past(group_bus[3])))
    else $error("reordered probe port wrong");

  chk_probe_group: assert property (@(posedge CLK) disable iff (SYS_RST)
    !probe_port_reorder |=> PROBE_PORT == $past(TEST_BUS_ALL[{probe_group_choice, 3'h0} +: 7]))
    else $error("wrong test bus on probe port");

  chk_aux_lines_off: assert property (@(posedge CLK) disable iff (SYS_RST)
    !uart_aux_lines_enable |=> !UART_AUX_LINE_A_EN && !UART_AUX_LINE_B_EN)
    else $error("aux lines not disabled");

  chk_parallel_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
    (HOST_IF == TPCR_IF_PARALLEL) |=> D_PORT.oe == 7'h00)
    else $error("pin driver active under parallel host");

  chk_spi_pin_limit: assert property (@(posedge CLK) disable iff (SYS_RST)
    (HOST_IF == TPCR_IF_SPI) |=> D_PORT.oe[6:5] == 2'h0)
    else $error("D5 or D6 driven under spi");

  chk_uart_pin_limit: assert property (@(posedge CLK) disable iff (SYS_RST)
    (HOST_IF == TPCR_IF_UART) && uart_aux_lines_enable |=> D_PORT.oe[6:5] == 2'h0)
    else $error("D5 or D6 driven under uart with aux lines");

  chk_driver_enable: assert property (@(posedge CLK) disable iff (SYS_RST)
    (HOST_IF == TPCR_IF_I2C) && PORT_GPIO_ENABLE && !secure_clock_to_pin_one |=>
      D_PORT.oe == $past(port_driver_enables))
    else $error("driver enables not applied");

  chk_pin_level: assert property (@(posedge CLK) disable iff (SYS_RST)
    !PORT_GPIO_ENABLE && !secure_clock_to_pin_one |=> D_PORT.oe == 7'h00)
    else $error("pin driven without gpio enable");

  chk_prbs_waits: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_armed_no_cmd ##1 (!TX_CMD && (prbs9_enable || prbs15_enable)) |-> s_stays_idle)
    else $error("pattern started without send command");

  chk_reserved_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
    HOST_REQ.rd && (addr_nxt == `TPCR_OFS_PAGE) |=> RD_DATA[6:2] == 5'h00)
    else $error("reserved bits read non-zero");

endmodule // tpcr_test_page_regs

// ===== src/tpcr_params.svh
// Constants of the test-page control registers: offsets, fields, resets.
// Assumes inclusion by bare name from every file that needs them.
`ifndef TPCR_PARAMS_SVH
`define TPCR_PARAMS_SVH

// ***************************************************************
// register offsets (6-bit register address)
// ***************************************************************
`define TPCR_OFS_PAGE        6'h30
`define TPCR_OFS_SEL_ONE     6'h31
`define TPCR_OFS_SEL_TWO     6'h32
`define TPCR_OFS_PIN_EN      6'h33

// ***************************************************************
// reset values and write masks
// ***************************************************************
`define TPCR_RST_PAGE        8'h00
`define TPCR_RST_SEL_ONE     8'h00
`define TPCR_RST_SEL_TWO     8'h00
`define TPCR_RST_PIN_EN      8'h80
`define TPCR_WMASK_PAGE      8'h83
`define TPCR_WMASK_SEL_ONE   8'h3F
`define TPCR_WMASK_SEL_TWO   8'hFF
`define TPCR_WMASK_PIN_EN    8'hFF

// ***************************************************************
// field positions
// ***************************************************************
`define TPCR_POS_PAGE_OVR    7
`define TPCR_POS_PAGE_NUM    0
`define TPCR_POS_CLK_SRC     4
`define TPCR_POS_CLK_D1      3
`define TPCR_POS_PROBE_BIT   0
`define TPCR_POS_REORDER     7
`define TPCR_POS_PRBS9       6
`define TPCR_POS_PRBS15      5
`define TPCR_POS_GROUP       0
`define TPCR_POS_AUX_EN      7
`define TPCR_POS_DRV_EN      0

// ***************************************************************
// pin limits and generator seeds
// ***************************************************************
`define TPCR_SERIAL_PIN_MASK 7'h1F
`define TPCR_ALL_PIN_MASK    7'h7F
`define TPCR_SEED_ONES       15'h7FFF

`endif

// ===== src/tpcr_pkg.sv
// Types shared by the test-page control register block.
// Assumes nothing beyond a SystemVerilog compiler.
package tpcr_pkg;

  // host interface in use, from the interface detector
  typedef enum logic [1:0] {
    TPCR_IF_PARALLEL = 2'h0,
    TPCR_IF_SPI      = 2'h1,
    TPCR_IF_UART     = 2'h2,
    TPCR_IF_I2C      = 2'h3
  } tpcr_host_if_t;

  // pattern generator states
  typedef enum logic [2:0] {
    TPCR_PG_IDLE  = 3'h1,
    TPCR_PG_ARMED = 3'h2,
    TPCR_PG_RUN   = 3'h4
  } tpcr_pg_state_t;

  // one register access from the host interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tpcr_req_t;

  // parallel data pins D6..D0
  typedef struct packed {
    logic [6:0] dout;
    logic [6:0] oe;
  } tpcr_port_t;

endpackage

// ===== src/tpcr_sync3.sv
// Three-stage synchroniser for levels from other clocks.
// Assumes the inputs are quasi-static with respect to CLK or glitch tolerant.
module tpcr_sync3
  import tpcr_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // ***************************************************************
  // per-bit stages; a change counts once stages two and three agree
  // ***************************************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
        q[i]    <= 1'b0;
      end else begin
        s1_r[i] <= d[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end

endmodule // tpcr_sync3

// ===== src/tpcr_prbs_gen.sv
// PRBS9 / PRBS15 test pattern generator.
// Assumes start and bit advance are one-cycle pulses from the transmitter.
`include "tpcr_params.svh"
module tpcr_prbs_gen
  import tpcr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en9,
  input  wire logic en15,
  input  wire logic start,
  input  wire logic adv,
  output logic      bit_out,
  output logic      run
);

  tpcr_pg_state_t state_r;
  logic [14:0]    lfsr_r;
  logic           mode9_r;
  logic           enabled;
  logic           fb;

  assign enabled = en9 | en15;
  assign fb      = mode9_r ? (lfsr_r[8] ^ lfsr_r[4]) : (lfsr_r[14] ^ lfsr_r[13]);

  // ***************************************************************
  // state: wait for the send command after enable
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= TPCR_PG_IDLE;
      mode9_r <= 1'b0;
    end else begin
      mode9_r <= en9;
      unique case (state_r)
        TPCR_PG_IDLE: begin
          if (enabled) begin
            state_r <= TPCR_PG_ARMED;
          end
        end
        TPCR_PG_ARMED: begin
          if (!enabled) begin
            state_r <= TPCR_PG_IDLE;
          end else if (start && (mode9_r == en9)) begin
            state_r <= TPCR_PG_RUN;
          end
        end
        TPCR_PG_RUN: begin
          if (!enabled) begin
            state_r <= TPCR_PG_IDLE;
          end else if (mode9_r != en9) begin
            state_r <= TPCR_PG_ARMED;
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // shift register, seeded to ones outside a run
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_r <= `TPCR_SEED_ONES;
    end else if (state_r != TPCR_PG_RUN) begin
      lfsr_r <= `TPCR_SEED_ONES;
    end else if (adv) begin
      lfsr_r <= {lfsr_r[13:0], fb};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bit_out <= 1'b0;
      run     <= 1'b0;
    end else begin
      bit_out <= (state_r == TPCR_PG_RUN) & (mode9_r ? lfsr_r[8] : lfsr_r[14]);
      run     <= (state_r == TPCR_PG_RUN);
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  chk_seed_on_start: assert property (@(posedge clk) disable iff (rst)
    (state_r == TPCR_PG_ARMED) ##1 (state_r == TPCR_PG_RUN) |-> lfsr_r == `TPCR_SEED_ONES)
    else $error("generator not seeded with ones at start");

  chk_prbs9_taps: assert property (@(posedge clk) disable iff (rst)
    (state_r == TPCR_PG_RUN) && mode9_r && en9 && adv |=>
      lfsr_r[0] == ($past(lfsr_r[8]) ^ $past(lfsr_r[4])))
    else $error("prbs9 feedback wrong");

  chk_prbs15_taps: assert property (@(posedge clk) disable iff (rst)
    (state_r == TPCR_PG_RUN) && !mode9_r && !en9 && en15 && adv |=>
      lfsr_r[0] == ($past(lfsr_r[14]) ^ $past(lfsr_r[13])))
    else $error("prbs15 feedback wrong");

endmodule // tpcr_prbs_gen

// ===== verification/tpcr_host_model.sv
// Host model: byte register accesses over the strobe interface.
// Assumes CLK from the bench; changes its outputs 1 ns after the rising edge.
module tpcr_host_model
  import tpcr_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic [7:0] RD_DATA,
  output tpcr_req_t       HOST_REQ,
  output logic      [5:0] ADDR_LATCH
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    HOST_REQ   = '0;
    ADDR_LATCH = 6'h00;
  end

  // data is scrambled once the strobe drops
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge CLK);
    #1;
    ADDR_LATCH = a;
    HOST_REQ   = '{wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge CLK);
    #1;
    HOST_REQ = '{wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge CLK);
    #1;
    ADDR_LATCH  = a;
    HOST_REQ.rd = 1'b1;
    @(posedge CLK);
    #1;
    HOST_REQ.rd = 1'b0;
    d           = RD_DATA;
  endtask
endmodule // tpcr_host_model

// ===== verification/test_test_page_config_regs.sv
// Self-checking bench of the test-page control registers.
// Assumes the host model for register access and a 40 MHz clock.
module test_test_page_config_regs;
  import tpcr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic          clk, sys_rst, osc, uclk, rf, gpio_en, tx_cmd, tx_adv;
  logic          sig_pin, sec_clk, aux_a, aux_b, prbs_bit, prbs_run, rd_hit;
  tpcr_host_if_t host_if;
  tpcr_req_t     req;
  tpcr_port_t    dport;
  logic [5:0]    latch, eff;
  logic [3:0]    low;
  logic [255:0]  tbus;
  logic [6:0]    pin_val, probe;
  logic [7:0]    rdata, v;
  logic [14:0]   lfsr;
  int            mismatches, checked;
  localparam logic [6:0] OE_EXP [4] = '{7'h00, 7'h1F, 7'h1F, 7'h7F};

  tpcr_host_model host (.CLK(clk), .RD_DATA(rdata), .HOST_REQ(req), .ADDR_LATCH(latch));
  tpcr_test_page_regs dut (.CLK(clk), .SYS_RST(sys_rst), .HOST_IF(host_if), .HOST_REQ(req),
    .ADDR_LATCH(latch), .ADDR_LOW(low), .TEST_BUS_ALL(tbus), .OSC_CLK_IN(osc), .UART_CLK_IN(uclk),
    .RF_CLK_IN(rf), .PORT_PIN_VALUES(pin_val), .PORT_GPIO_ENABLE(gpio_en), .TX_CMD(tx_cmd),
    .TX_BIT_ADV(tx_adv), .EFF_ADDR(eff), .RD_DATA(rdata), .RD_HIT(rd_hit), .SIGNAL_OUTPUT_PIN(sig_pin),
    .PROBE_PORT(probe), .D_PORT(dport), .SECURE_CLK_OUT(sec_clk), .UART_AUX_LINE_A_EN(aux_a),
    .UART_AUX_LINE_B_EN(aux_b), .PRBS_BIT(prbs_bit), .PRBS_RUN(prbs_run));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_reg(input logic [5:0] a, input logic [7:0] exp);
    host.rd(a, v);
    cmp(v, exp);
  endtask

  task automatic end_of_test;
    $display("mismatches %0d, checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    sys_rst = 1'b1;
    {osc, uclk, rf, tx_cmd, tx_adv} = 5'h00;
    gpio_en = 1'b1;
    host_if = TPCR_IF_SPI;
    low     = 4'h0;
    pin_val = 7'h7F;
    tbus    = '0;
    tbus[47:40] = 8'h4B;
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk_reg(6'h30, 8'h00);
    chk_reg(6'h31, 8'h00);
    chk_reg(6'h32, 8'h00);
    chk_reg(6'h33, 8'h80);
    cmp({7'h00, rd_hit}, 8'h01);
    cmp({6'h00, aux_a, aux_b}, 8'h03);
    // reserved bits and page override
    host.wr(6'h31, 8'hFF);
    chk_reg(6'h31, 8'h3F);
    host.wr(6'h31, 8'h00);
    host.wr(6'h30, 8'hFF);
    chk_reg(6'h05, 8'h83);
    low = 4'h2;
    host.wr(6'h05, 8'h1A);
    tk(1);
    cmp({2'b00, eff}, 8'h32);
    low = 4'h0;
    host.wr(6'h05, 8'h03);
    chk_reg(6'h32, 8'h1A);
    host.rd(6'h05, v);
    cmp(v, 8'h00);
    cmp({7'h00, rd_hit}, 8'h00);
    // driver enables per host interface
    host.wr(6'h33, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      host_if = tpcr_host_if_t'(i[1:0]);
      tk(2);
      cmp({1'b0, dport.oe}, {1'b0, OE_EXP[i]});
      cmp({1'b0, dport.dout & dport.oe}, {1'b0, OE_EXP[i]});
    end
    gpio_en = 1'b0;
    tk(2);
    cmp({1'b0, dport.oe}, 8'h00);
    gpio_en = 1'b1;
    host.wr(6'h33, 8'h7F);
    host_if = TPCR_IF_UART;
    tk(2);
    cmp({1'b0, dport.oe}, 8'h7F);
    cmp({6'h00, aux_a, aux_b}, 8'h00);
    // probes: group 5, reordered port
    host.wr(6'h32, 8'h85);
    for (int b = 0; b < 8; b++) begin
      host.wr(6'h31, {5'h00, b[2:0]});
      tk(2);
      cmp({7'h00, sig_pin}, {7'h00, tbus[40 + b]});
    end
    cmp({1'b0, probe}, 8'h53);
    // secure clock sources onto D1
    host_if = TPCR_IF_SPI;
    for (int s = 0; s < 4; s++) begin
      osc  = (s == 1);
      uclk = (s == 2);
      rf   = (s == 3);
      host.wr(6'h31, {2'b00, s[1:0], 4'h8});
      tk(6);
      cmp({7'h00, sec_clk}, {7'h00, s != 0});
      cmp({7'h00, dport.dout[1]}, {7'h00, s != 0});
    end
    // pattern generators
    for (int m = 0; m < 2; m++) begin
      host.wr(6'h32, m == 0 ? 8'h40 : 8'h20);
      tk(2);
      cmp({7'h00, prbs_run}, 8'h00);
      tx_cmd = 1'b1;
      tk(1);
      tx_cmd = 1'b0;
      tk(2);
      cmp({7'h00, prbs_run}, 8'h01);
      lfsr = 15'h7FFF;
      for (int i = 0; i < 20; i++) begin
        cmp({7'h00, prbs_bit}, {7'h00, m == 0 ? lfsr[8] : lfsr[14]});
        tx_adv = 1'b1;
        tk(1);
        tx_adv = 1'b0;
        tk(2);
        lfsr = m == 0 ? {6'h00, lfsr[7:0], lfsr[8] ^ lfsr[4]} : {lfsr[13:0], lfsr[14] ^ lfsr[13]};
      end
      host.wr(6'h32, 8'h00);
      tk(3);
      cmp({7'h00, prbs_run}, 8'h00);
    end
    end_of_test();
  end
endmodule // test_test_page_config_regs
